/* File: src/psmc_hard_powerdown_pin.sv */
`timescale 1ns/100ps
module psmc_hard_powerdown_pin
   import psmc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Sequencer signals
   psmc_tick_if.seq tif
);
   psmc_hw_t state;
   logic [1:0] mcs;

   // External reset always wins over hardware power down
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state <= PSMC_HW_RUN; // R24
         mcs <= 2'h0;
      end else begin
         case (state)
            PSMC_HW_RUN: begin
               if (tif.mc_tick && tif.pd_req) begin
                  state <= PSMC_HW_RESET; // R19
                  mcs <= 2'h0;
               end
            end
            PSMC_HW_RESET: begin
               if (tif.mc_tick) begin
                  mcs <= mcs + 2'h1;
                  if (mcs == PSMC_HW_RESET_MCS - 2'h1) begin
                     state <= tif.pd_req ? PSMC_HW_OFF : PSMC_HW_RUN; // R20 R25
                  end
               end
            end
            PSMC_HW_OFF: begin
               // No machine cycles here, so the pin is watched every clock
               if (!tif.pd_req) begin
                  state <= PSMC_HW_WAKE; // R23
               end
            end
            PSMC_HW_WAKE: begin
               if (tif.osc_ready) begin
                  state <= PSMC_HW_RUN; // R23
               end
            end
            default: state <= PSMC_HW_RUN;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tif.hw_wdt_clear <= 1'b0;
         tif.hw_osc_flag_set <= 1'b0;
      end else begin
         tif.hw_wdt_clear <= state == PSMC_HW_RUN && tif.mc_tick && tif.pd_req; // R20
         tif.hw_osc_flag_set <= state == PSMC_HW_WAKE && tif.osc_ready; // R23
      end
   end

   assign tif.hw_int_reset = state == PSMC_HW_RESET || state == PSMC_HW_WAKE; // R20 R23
   assign tif.hw_float = state == PSMC_HW_OFF; // R21
   assign tif.hw_osc_off = state == PSMC_HW_OFF; // R21
   assign tif.hw_state = state;
endmodule : psmc_hard_powerdown_pin

/* File: src/psmc_mcycle.sv */
`timescale 1ns/100ps
module psmc_mcycle
   import psmc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Timing to the sequencer
   psmc_tick_if.timer tif
);
   logic [6:0] cnt;
   logic [6:0] last;

   function automatic logic [6:0] psmc_last(input logic slow);
      logic [13:0] len;
      len = slow ? {7'h00, PSMC_MC_CLKS} * {7'h00, PSMC_SLOW_FACTOR}
         : {7'h00, PSMC_MC_CLKS};
      return len[6:0] - 7'h01;
   endfunction : psmc_last

   // Slow down stretches the whole machine cycle, so every derived rate drops
   assign last = psmc_last(tif.slow_active); // R16

   always_ff @(posedge core_clk) begin
      if (!rst_b || tif.stop_all) begin
         cnt <= 7'h00;
      end else if (cnt >= last) begin
         cnt <= 7'h00;
      end else begin
         cnt <= cnt + 7'h01;
      end
   end

   // Clock output runs at machine rate, divided with everything else in slow down
   always_ff @(posedge core_clk) begin
      if (!rst_b || tif.stop_all) begin
         tif.clk_out <= 1'b0; // R09
      end else begin
         tif.clk_out <= cnt <= {1'b0, last[6:1]}; // R16
      end
   end

   assign tif.mc_tick = !tif.stop_all && (cnt == last); // R16
endmodule : psmc_mcycle

/* File: src/psmc_pkg.sv */
package psmc_pkg;
   // ==========================================================
   // Register map (byte addresses on the APB)
   localparam logic [7:0] PSMC_OFF_CTRL = 8'h00;
   localparam logic [7:0] PSMC_OFF_STAT = 8'h04;
   // ==========================================================
   // Control register fields
   localparam int PSMC_B_LIGHT_ARM = 0;
   localparam int PSMC_B_DEEP_ARM = 1;
   localparam int PSMC_B_GF0 = 2;
   localparam int PSMC_B_GF1 = 3;
   localparam int PSMC_B_CLK_DIV = 4;
   localparam int PSMC_B_LIGHT_START = 5;
   localparam int PSMC_B_DEEP_START = 6;
   localparam logic [7:0] PSMC_CTRL_RESET = 8'h00;
   // ==========================================================
   // Timing: machine cycle length in core clock cycles, hardware reset length in machine cycles
   localparam logic [6:0] PSMC_MC_CLKS = 7'h0C;
   localparam logic [6:0] PSMC_SLOW_FACTOR = 7'h08;
   localparam logic [1:0] PSMC_HW_RESET_MCS = 2'h2;
   // ==========================================================
   typedef enum logic [1:0] {PSMC_RUN, PSMC_IDLE, PSMC_SWPD} psmc_mode_t;
   typedef enum logic [1:0] {PSMC_HW_RUN, PSMC_HW_RESET, PSMC_HW_OFF, PSMC_HW_WAKE} psmc_hw_t;
endpackage : psmc_pkg

/* File: src/psmc_tick_if.sv */
`timescale 1ns/100ps
interface psmc_tick_if;
   logic mc_tick;
   logic clk_out;
   logic slow_active;
   logic stop_all;
   logic pd_req;
   logic osc_ready;
   logic hw_int_reset;
   logic hw_float;
   logic hw_osc_off;
   logic hw_wdt_clear;
   logic hw_osc_flag_set;
   logic [1:0] hw_state;
   modport timer (output mc_tick, output clk_out, input slow_active, input stop_all);
   modport seq (input mc_tick, input pd_req, input osc_ready, output hw_int_reset,
      output hw_float, output hw_osc_off, output hw_wdt_clear, output hw_osc_flag_set,
      output hw_state);
endinterface : psmc_tick_if

/* File: src/psmc_top.sv */
// Summary of operation
// R01: Idle stops CPU and watchdog clocks; other peripherals keep running.
// R02: Outside logic holds the enable pin low to allow idle entry.
// R03: Idle entry: write light arm alone, then very next write light start alone.
// R04: A write setting light arm and start together never enters idle.
// R05: Light arm and start bits self-clear and always read zero.
// R06: Any enabled interrupt ends idle; execution resumes after the start write.
// R07: Hardware reset ends idle; two machine cycles of reset suffice.
// R08: Software power down stops the oscillator and all functions, keeps state.
// R09: In power down ports hold values and the clock output stops low.
// R10: In power down address strobe and fetch strobe are driven low.
// R11: Power down entry: pin low, deep arm write, then deep start write alone.
// R12: Deep arm with start together does nothing; both bits self-clear, read zero.
// R13: Simultaneous idle and power down requests give power down.
// R14: Only hardware reset leaves power down; it restarts the oscillator.
// R15: Outside reset must last long enough for oscillator restart.
// R16: Slow down divides all oscillator-derived rates, clock output too, by eight.
// R17: Divide bit with pin low enters slow down within two machine cycles.
// R18: Monitor enable pin high for hardware power down; enable pin irrelevant.
// R19: Hardware power-down pin is sampled once per machine cycle, low requests.
// R20: A request runs a two machine cycle internal reset, clearing watchdog.
// R21: Afterwards both oscillators stop and ports and control lines float.
// R22: With the enable pin high software entry sequences are ignored.
// R23: Pin high again: pins reset, oscillators on, reset held until clock runs.
// R24: Hardware reset ends hardware power down with a normal reset.
// R25: A single active sample gives an internal reset, then normal running.
// R26: An armed bit not followed by its start write is discarded.
`timescale 1ns/100ps
module psmc_top
   import psmc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device pins
   input wire logic power_save_enable_pin_b,
   input wire logic hard_powerdown_pin_b,
   input wire logic osc_monitor_enable_pin,
   input wire logic main_osc_running,
   // Core side
   input wire logic wake_irq,
   output logic cpu_clk_en,
   output logic watchdog_clk_en,
   output logic periph_clk_en,
   output logic machine_tick,
   output logic clock_output_pin,
   output logic osc_enable,
   output logic rc_osc_enable,
   output logic internal_reset,
   output logic watchdog_reset_flag_clear,
   output logic osc_monitor_flag_set,
   // Pin state control
   output logic strobes_hold_high,
   output logic strobes_hold_low,
   output logic port_hold,
   output logic port_float
);
   // ==========================================================
   // Pin synchronisers
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic pse_low;
   logic pd_low;
   logic owe_high;
   logic osc_run;

   always_ff @(posedge core_clk) begin
      // Idle pin levels, so no false request or enable follows reset
      if (!rst_b) begin
         pin_s1 <= 4'hF;
         pin_s2 <= 4'hF;
      end else begin
         pin_s1 <= {main_osc_running, osc_monitor_enable_pin,
            hard_powerdown_pin_b, power_save_enable_pin_b};
         pin_s2 <= pin_s1;
      end
   end

   assign pse_low = !pin_s2[0];
   assign pd_low = !pin_s2[1];
   assign owe_high = pin_s2[2];
   assign osc_run = pin_s2[3];

   // ==========================================================
   // Timing and hardware power down
   psmc_tick_if tif ();
   psmc_mode_t mode;
   logic sys_rst;
   logic slow_active;

   psmc_mcycle u_mcycle (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .tif(tif.timer)
   );

   psmc_hard_powerdown_pin u_hard_powerdown_pin (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .tif(tif.seq)
   );

   // Enable pin plays no part here; wake needs the monitor enabled
   assign tif.pd_req = pd_low; // R18
   assign tif.osc_ready = osc_run && owe_high; // R18 R23
   assign tif.slow_active = slow_active;
   assign tif.stop_all = mode == PSMC_SWPD || tif.hw_osc_off; // R08

   // Internal reset from the sequencer acts like the reset pin
   assign sys_rst = !rst_b || tif.hw_int_reset; // R20 R23

   // ==========================================================
   // Register access
   logic acc;
   logic wr_ctrl;
   logic mapped;
   logic [7:0] wd;
   logic [1:0] gen_flags;
   logic clock_divide;
   logic light_armed;
   logic deep_armed;
   logic light_go;
   logic deep_go;

   assign mapped = paddr == PSMC_OFF_CTRL || paddr == PSMC_OFF_STAT;
   assign acc = psel && penable;
   assign wr_ctrl = acc && pwrite && paddr == PSMC_OFF_CTRL;
   assign wd = pwdata[7:0];
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;

   // Entry sequences are blocked outright while the enable pin is high
   assign light_go = wr_ctrl && pse_low && light_armed && wd[PSMC_B_LIGHT_START]
      && !wd[PSMC_B_LIGHT_ARM]; // R03 R04 R22
   assign deep_go = wr_ctrl && pse_low && deep_armed && wd[PSMC_B_DEEP_START]
      && !wd[PSMC_B_DEEP_ARM]; // R11 R12 R22

   // Any write to the control register consumes a pending arm
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         light_armed <= 1'b0;
         deep_armed <= 1'b0;
      end else if (wr_ctrl) begin
         light_armed <= pse_low && wd[PSMC_B_LIGHT_ARM] && !wd[PSMC_B_LIGHT_START]; // R03 R26
         deep_armed <= pse_low && wd[PSMC_B_DEEP_ARM] && !wd[PSMC_B_DEEP_START]; // R11 R26
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gen_flags <= PSMC_CTRL_RESET[PSMC_B_GF1:PSMC_B_GF0];
      end else if (wr_ctrl) begin
         gen_flags <= wd[PSMC_B_GF1:PSMC_B_GF0];
      end
   end

   // Setting the divider needs the pin low; clearing is always allowed
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clock_divide <= PSMC_CTRL_RESET[PSMC_B_CLK_DIV];
      end else if (wr_ctrl && (pse_low || !wd[PSMC_B_CLK_DIV])) begin
         clock_divide <= wd[PSMC_B_CLK_DIV]; // R17 R22
      end
   end

   // Divider change waits for a machine cycle boundary
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slow_active <= 1'b0;
      end else if (tif.mc_tick) begin
         slow_active <= clock_divide; // R16 R17
      end
   end

   // ==========================================================
   // Power mode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode <= PSMC_RUN; // R07 R14
      end else begin
         case (mode)
            PSMC_RUN: begin
               if (deep_go) begin
                  mode <= PSMC_SWPD; // R13
               end else if (light_go) begin
                  mode <= PSMC_IDLE;
               end
            end
            PSMC_IDLE: begin
               if (wake_irq) begin
                  mode <= PSMC_RUN; // R06
               end
            end
            // Frozen until a reset
            PSMC_SWPD: mode <= PSMC_SWPD; // R14
            default: mode <= PSMC_RUN;
         endcase
      end
   end

   // ==========================================================
   // Read data, registered in the setup phase
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr == PSMC_OFF_CTRL) begin
            // Arm and start bits read zero here; the armed state shows in the status register
            prdata[PSMC_B_GF1:PSMC_B_GF0] <= gen_flags; // R05 R12
            prdata[PSMC_B_CLK_DIV] <= clock_divide;
         end else if (paddr == PSMC_OFF_STAT) begin
            prdata[7:0] <= {tif.hw_state, mode, slow_active, light_armed,
               deep_armed, pse_low};
         end
      end
   end

   // ==========================================================
   // Clocks and pins
   assign cpu_clk_en = mode == PSMC_RUN && !tif.hw_osc_off; // R01
   assign watchdog_clk_en = mode == PSMC_RUN && !tif.hw_osc_off && !tif.hw_int_reset; // R01 R20
   assign periph_clk_en = mode != PSMC_SWPD && !tif.hw_osc_off; // R01 R08
   assign machine_tick = tif.mc_tick;
   // Register lags the stop by a cycle, so gate it here
   assign clock_output_pin = tif.clk_out && !tif.stop_all; // R09 R16
   assign osc_enable = mode != PSMC_SWPD && !tif.hw_osc_off; // R08 R21
   assign rc_osc_enable = !tif.hw_osc_off; // R21
   assign internal_reset = sys_rst; // R20
   assign watchdog_reset_flag_clear = tif.hw_wdt_clear; // R20
   assign osc_monitor_flag_set = tif.hw_osc_flag_set; // R23
   assign strobes_hold_high = mode == PSMC_IDLE;
   assign strobes_hold_low = mode == PSMC_SWPD; // R10
   assign port_hold = mode == PSMC_SWPD; // R09
   assign port_float = tif.hw_float; // R21
endmodule : psmc_top

/* File: test/psmc_chk.sv */
`timescale 1ns/100ps
module psmc_chk
   import psmc_pkg::*;
(
   // Clock, reset, bus
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   // Pins and core side
   input wire logic power_save_enable_pin_b,
   input wire logic cpu_clk_en,
   input wire logic watchdog_clk_en,
   input wire logic periph_clk_en,
   input wire logic machine_tick,
   input wire logic clock_output_pin,
   input wire logic osc_enable,
   input wire logic rc_osc_enable,
   input wire logic internal_reset,
   input wire logic strobes_hold_high,
   input wire logic strobes_hold_low,
   input wire logic port_float
);
   default clocking cb @(posedge core_clk);
   endclocking
   // ======
   // Tick spacing, unchecked until one full cycle is seen
   logic [6:0] gap;
   logic seen;
   always_ff @(posedge core_clk) begin
      if (!rst_b || internal_reset || strobes_hold_low) begin
         gap <= 7'h00;
         seen <= 1'b0;
      end else if (machine_tick) begin
         gap <= 7'h00;
         seen <= 1'b1;
      end else begin
         gap <= gap + 7'h01;
      end
   end
   // ======
   // Checks
   idle_gate_a:
      assert property (disable iff (!rst_b) strobes_hold_high |-> !cpu_clk_en &&
      !watchdog_clk_en && periph_clk_en) else $error("idle gating wrong");
   swpd_stop_a:
      assert property (disable iff (!rst_b) strobes_hold_low |-> !periph_clk_en &&
      !clock_output_pin && !strobes_hold_high) else $error("power down not frozen");
   read_zero_a:
      assert property (psel && penable && !pwrite && paddr == PSMC_OFF_CTRL |->
      prdata[6:5] == 2'h0 && prdata[1:0] == 2'h0) else $error("start or arm reads one");
   reset_exit_a:
      assert property (!rst_b |=> !strobes_hold_high && !strobes_hold_low)
      else $error("reset left a mode active");
   int_reset_a:
      assert property (!rst_b |=> !port_float && rc_osc_enable)
      else $error("reset left hardware power down active");
   float_osc_a:
      assert property (disable iff (!rst_b) port_float |-> !osc_enable &&
      !rc_osc_enable && !machine_tick) else $error("float with clocks");
   float_after_a:
      assert property (disable iff (!rst_b) $rose(port_float) |-> $past(internal_reset))
      else $error("float without internal reset");
   pin_gate_a:
      assert property (disable iff (!rst_b) $rose(strobes_hold_high || strobes_hold_low)
      |-> !$past(power_save_enable_pin_b, 3)) else $error("mode entered while blocked");
   tick_gap_a:
      assert property (disable iff (!rst_b) machine_tick && seen |-> gap == 7'h0B ||
      gap == 7'h5F) else $error("machine cycle length wrong");
   cover property (disable iff (!rst_b) $rose(strobes_hold_high));
   cover property (disable iff (!rst_b) $rose(strobes_hold_low));
   cover property (disable iff (!rst_b) $rose(port_float));
endmodule : psmc_chk
bind psmc_top psmc_chk i_chk (.*);

/* File: test/psmc_supervisor.sv */
`timescale 1ns/100ps
module psmc_supervisor (
   // Clock
   input wire logic core_clk,
   // Bench commands, oscillator enable
   input wire logic power_fail,
   input wire logic cut_power,
   input wire logic [7:0] start_clks,
   input wire logic osc_enable,
   // Pins to the device
   output logic power_save_enable_pin_b,
   output logic hard_powerdown_pin_b,
   output logic osc_monitor_enable_pin,
   output logic main_osc_running
);
   logic [7:0] warm;
   initial begin
      power_save_enable_pin_b = 1'b1;
      hard_powerdown_pin_b = 1'b1;
      osc_monitor_enable_pin = 1'b1;
      main_osc_running = 1'b1;
      warm = 8'h00;
   end
   // Crystal is slow to start, so wake must wait on it
   always @(posedge core_clk) begin
      power_save_enable_pin_b <= !power_fail;
      hard_powerdown_pin_b <= !cut_power;
      osc_monitor_enable_pin <= 1'b1;
      warm <= osc_enable ? warm + {7'h00, warm != start_clks} : 8'h00;
      main_osc_running <= osc_enable && warm == start_clks;
   end
endmodule : psmc_supervisor

/* File: test/psmc_top_tb.sv */
`timescale 1ns/100ps
module psmc_top_tb
   import psmc_pkg::*;
;
   logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic wake_irq = 1'b0, power_fail = 1'b0, cut_power = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00, start_clks = 8'h28;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic power_save_enable_pin_b, hard_powerdown_pin_b, osc_monitor_enable_pin;
   logic main_osc_running, cpu_clk_en, watchdog_clk_en, periph_clk_en, machine_tick;
   logic clock_output_pin, osc_enable, rc_osc_enable, internal_reset, port_float;
   logic watchdog_reset_flag_clear, osc_monitor_flag_set, strobes_hold_high;
   logic strobes_hold_low, port_hold;
   int mismatches = 0, comparisons = 0, n, m;
   psmc_top i_dut (.*);
   psmc_supervisor i_sup (.*);
   always #25 core_clk = ~core_clk;
   // ======
   // Helpers
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_for(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      if (s !== v) begin
         mismatches++;
         conclude();
      end
   endtask : wait_for
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      // Access phase lasts until pready is seen high at a rising edge
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 3000);
      if (pready !== 1'b1) begin
         mismatches++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic tick_len(input int exp);
      wait_for(machine_tick, 1'b1);
      @(posedge core_clk);
      m = 1;
      while (machine_tick !== 1'b1 && m < 200) begin
         @(posedge core_clk);
         m++;
      end
      check(m, exp);
   endtask : tick_len
   // ======
   // Scenarios
   task automatic t_regs;
      apb(0, PSMC_OFF_CTRL, 8'h00);
      check(rd, {24'h0, PSMC_CTRL_RESET});
      apb(1, PSMC_OFF_CTRL, 8'h6F);
      apb(0, PSMC_OFF_CTRL, 8'h00);
      check(rd, 32'h0C);
      apb(0, 8'h08, 8'h00);
      check(err, 1'b1);
      apb(1, 0, 8'h01);
      apb(1, 0, 8'h20);
      repeat (4) @(posedge core_clk);
      check({strobes_hold_high, cpu_clk_en}, 2'b01);
      power_fail <= 1'b1;
      $display("done regs");
   endtask : t_regs
   task automatic t_seq;
      repeat (4) @(posedge core_clk);
      apb(1, 0, 8'h21);
      apb(1, 0, 8'h42);
      apb(1, 0, 8'h01);
      apb(1, 0, 8'h0C);
      apb(1, 0, 8'h20);
      repeat (3) @(posedge core_clk);
      check({strobes_hold_high, strobes_hold_low, cpu_clk_en}, 3'b001);
      apb(1, 0, 8'h0D);
      apb(1, 0, 8'h2C);
      repeat (3) @(posedge core_clk);
      check({strobes_hold_high, cpu_clk_en, watchdog_clk_en, periph_clk_en}, 4'h9);
      apb(0, 0, 8'h00);
      check(rd, 32'h0C);
      wake_irq <= 1'b1;
      wait_for(cpu_clk_en, 1'b1);
      wake_irq <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(strobes_hold_high, 1'b0);
      $display("done idle");
   endtask : t_seq
   task automatic t_slow;
      apb(1, 0, 8'h1C);
      repeat (24) @(posedge core_clk);
      apb(0, PSMC_OFF_STAT, 8'h00);
      check(rd[3], 1'b1);
      tick_len(96);
      apb(1, 0, 8'h0C);
      repeat (200) @(posedge core_clk);
      tick_len(12);
      $display("done slow");
   endtask : t_slow
   task automatic t_swpd;
      apb(1, 0, 8'h03);
      apb(1, 0, 8'h60);
      repeat (3) @(posedge core_clk);
      check({strobes_hold_low, strobes_hold_high, clock_output_pin, cpu_clk_en, port_hold},
         5'h11);
      rst_b <= 1'b0;
      repeat (60) @(posedge core_clk);
      rst_b <= 1'b1;
      wait_for(cpu_clk_en, 1'b1);
      check(strobes_hold_low, 1'b0);
      apb(0, 0, 8'h00);
      check(rd, 32'h00);
      $display("done power down");
   endtask : t_swpd
   task automatic t_hard_powerdown_pin;
      cut_power <= 1'b1;
      wait_for(internal_reset, 1'b1);
      check(watchdog_reset_flag_clear, 1'b1);
      wait_for(port_float, 1'b1);
      check({osc_enable, rc_osc_enable}, 2'b00);
      cut_power <= 1'b0;
      wait_for(internal_reset, 1'b1);
      wait_for(internal_reset, 1'b0);
      check(osc_monitor_flag_set, 1'b1);
      check({port_float, osc_enable, cpu_clk_en}, 3'b011);
      repeat (30) @(posedge core_clk);
      cut_power <= 1'b1;
      repeat (12) @(posedge core_clk);
      cut_power <= 1'b0;
      wait_for(internal_reset, 1'b1);
      wait_for(internal_reset, 1'b0);
      repeat (30) @(posedge core_clk);
      check({port_float, cpu_clk_en}, 2'b01);
      cut_power <= 1'b1;
      wait_for(port_float, 1'b1);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      check({port_float, rc_osc_enable, osc_enable}, 3'b011);
      cut_power <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      $display("done hardware power down");
   endtask : t_hard_powerdown_pin
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      t_regs();
      t_seq();
      t_slow();
      t_swpd();
      t_hard_powerdown_pin();
      conclude();
   end
endmodule : psmc_top_tb
